// file: shared/amx_map.svh
// Register addresses, field positions, reset values and timing counts of the switch status block.
`ifndef AMX_MAP_SVH
`define AMX_MAP_SVH

// ==========================================================================
// Frame layout
`define AMX_FRAME_BITS 6'd32
`define AMX_STAT_FAULT_BIT 23
`define AMX_STAT_INT_BIT 22

// ==========================================================================
// Register addresses (seven-bit frame address)
`define AMX_ADDR_MUX_CTRL 7'h1D
`define AMX_ADDR_SW_STATUS 7'h1F
`define AMX_ADDR_FAULT 7'h21
`define AMX_ADDR_LINK_CHECK 7'h01
`define AMX_ADDR_WET_CFG 7'h02

// ==========================================================================
// Multiplexer control fields and reset value
`define AMX_MUX_CTRL_RST 7'h00
`define AMX_MUX_SEL_MSB 5
`define AMX_MUX_CUR_BIT 6
`define AMX_CHAN_LAST 6'h18

// ==========================================================================
// Interrupt pin release time
`define AMX_INT_RELEASE_NS 1000000
`define AMX_CLK_PERIOD_NS 5
`define AMX_INT_RELEASE_CYCLES (`AMX_INT_RELEASE_NS / `AMX_CLK_PERIOD_NS)

`endif

// file: shared/amx_pkg.sv
// Types shared by the switch status block.
package amx_pkg;

    typedef struct packed {
        logic [6:0] addr;
        logic write;
        logic [23:0] data;
    } amx_frame_s;

    typedef struct packed {
        logic [7:0] programmable;
        logic [13:0] ground;
    } amx_switch_s;

    typedef enum logic [1:0] {
        AMX_SH_IDLE = 2'b01,
        AMX_SH_FRAME = 2'b10
    } amx_shift_e;

endpackage : amx_pkg

// file: verilog/amx_delay_timer.sv
// One-shot down counter that pulses once a fixed number of cycles after a start pulse.
`timescale 1ns/1ps
`default_nettype none

module amx_delay_timer
    import amx_pkg::*;
#(
    parameter int CYCLES = 200000
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic start,
    output logic expire
);

    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic expire_reg;
    logic expire_next;

    // A new start simply reloads the count, so the last start always wins.
    always_comb
    begin
        count_next = count_reg;
        expire_next = 1'b0;
        if (start)
        begin
            count_next = W'(CYCLES);
        end
        else if (count_reg != '0)
        begin
            count_next = count_reg - W'(1);
            expire_next = (count_reg == W'(1));
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_reg <= '0;
            expire_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            expire_reg <= expire_next;
        end
    end

    assign expire = expire_reg;

endmodule : amx_delay_timer
`default_nettype wire

// file: verilog/amx_spi_shifter.sv
// Serial frame shifter: samples the link pins and moves 32-bit words in and out.
`timescale 1ns/1ps
`default_nettype none
`include "amx_map.svh"

module amx_spi_shifter
    import amx_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    input wire logic [31:0] txWord,
    output logic csFall,
    output logic frameDone,
    output amx_frame_s rxFrame,
    output logic spiMiso,
    output logic spiMisoOe
);

    amx_shift_e state_reg, state_next;
    logic sclkPrev_reg;
    logic csPrev_reg;
    logic [5:0] bitCnt_reg, bitCnt_next;
    logic [31:0] rxShift_reg, rxShift_next;
    logic [31:0] txShift_reg, txShift_next;
    logic miso_reg, miso_next;
    logic oe_reg, oe_next;
    logic csFall_reg, csFall_next;
    logic done_reg, done_next;
    amx_frame_s rxFrame_reg, rxFrame_next;
    logic sclkRise;
    logic sclkFall;

    // Data is taken on the rising clock edge and changed on the falling one.
    always_comb
    begin
        sclkRise = !sclkPrev_reg && spiSclk && !spiCsN;
        sclkFall = sclkPrev_reg && !spiSclk && !spiCsN;
        state_next = state_reg;
        bitCnt_next = bitCnt_reg;
        rxShift_next = rxShift_reg;
        txShift_next = txShift_reg;
        miso_next = miso_reg;
        oe_next = oe_reg;
        csFall_next = 1'b0;
        done_next = 1'b0;
        rxFrame_next = rxFrame_reg;
        case (state_reg)
            AMX_SH_IDLE:
            begin
                if (csPrev_reg && !spiCsN)
                begin
                    state_next = AMX_SH_FRAME;
                    txShift_next = txWord;
                    miso_next = txWord[31];
                    oe_next = 1'b1;
                    bitCnt_next = 6'h00;
                    csFall_next = 1'b1;
                end
            end
            AMX_SH_FRAME:
            begin
                if (spiCsN)
                begin
                    state_next = AMX_SH_IDLE;
                    oe_next = 1'b0;
                    // A frame of any other length is dropped whole. [RL17] [RL20]
                    done_next = (bitCnt_reg == `AMX_FRAME_BITS);
                    rxFrame_next = rxShift_reg;
                end
                else
                begin
                    if (sclkRise)
                    begin
                        rxShift_next = {rxShift_reg[30:0], spiMosi};
                        if (bitCnt_reg != 6'h3F)
                        begin
                            bitCnt_next = bitCnt_reg + 6'h01;
                        end
                    end
                    if (sclkFall)
                    begin
                        txShift_next = {txShift_reg[30:0], 1'b0};
                        miso_next = txShift_reg[30];
                    end
                end
            end
            default:
            begin
                state_next = AMX_SH_IDLE;
                oe_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= AMX_SH_IDLE;
            sclkPrev_reg <= 1'b0;
            csPrev_reg <= 1'b1;
            bitCnt_reg <= 6'h00;
            rxShift_reg <= 32'h00000000;
            txShift_reg <= 32'h00000000;
            miso_reg <= 1'b0;
            oe_reg <= 1'b0;
            csFall_reg <= 1'b0;
            done_reg <= 1'b0;
            rxFrame_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            sclkPrev_reg <= spiSclk;
            csPrev_reg <= spiCsN;
            bitCnt_reg <= bitCnt_next;
            rxShift_reg <= rxShift_next;
            txShift_reg <= txShift_next;
            miso_reg <= miso_next;
            oe_reg <= oe_next;
            csFall_reg <= csFall_next;
            done_reg <= done_next;
            rxFrame_reg <= rxFrame_next;
        end
    end

    assign csFall = csFall_reg;
    assign frameDone = done_reg;
    assign rxFrame = rxFrame_reg;
    assign spiMiso = miso_reg;
    assign spiMisoOe = oe_reg;

endmodule : amx_spi_shifter
`default_nettype wire

// file: verilog/amx_switch_status.sv
// Analog multiplexer control and switch status word of the switch detection device.
`timescale 1ns/1ps
`default_nettype none
`include "amx_map.svh"

// Behaviour
// RL1: Mux control resets to no channel selected.
// RL2: Channel code routes chosen input to analog output.
// RL3: Bit 6 picks high impedance or wetting current.
// RL4: Selected input reads zero in next status.
// RL5: Channel selection may be rewritten any time.
// RL6: Status register read only, returned next frame.
// RL7: Status bit one means switch closed.
// RL8: Fault 23, interrupt 22, programmable, then ground.
// RL9: Fault status ORs extended and wetting faults.
// RL10: Switch change or new fault sets interrupt.
// RL11: Power-on sets fault status and interrupt flag.
// RL12: Fault status holds until fault register read.
// RL13: Present fault sets its flag again immediately.
// RL14: Any response carrying interrupt flag clears it.
// RL15: Persisting fault raises no new interrupt.
// RL16: Responses carry flags except two config registers.
// RL17: Read frame is 32 clocks after chip select.
// RL18: Interrupt pin released 1 ms after select.
// RL19: Fault flags come back in next response. Code sends only their OR in bit 23; a fault read returns zero in bits 21:0.
// RL20: Frame is address, write flag, 24 data.
module amx_switch_status
    import amx_pkg::*;
#(
    parameter int EXT_FAULTS = 8,
    parameter int WET_FAULTS = 22,
    parameter int INT_RELEASE_CYCLES = `AMX_INT_RELEASE_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    input wire amx_switch_s switchClosed,
    input wire logic [EXT_FAULTS-1:0] extFaultCond,
    input wire logic [WET_FAULTS-1:0] wetFaultCond,
    output logic spiMiso,
    output logic spiMisoOe,
    output logic [5:0] analogChannelSel,
    output logic analogSourceCurrentSel,
    output logic [23:0] analogRoute,
    output logic intN
);

    // ======================================================================
    // Channel decode

    // Code n selects route bit n-1; zero and codes past the battery sense select nothing.
    function automatic logic [23:0] chanToOnehot(input logic [5:0] code);
        logic [23:0] result;
        result = 24'h000000;
        if (code != 6'h00 && code <= `AMX_CHAN_LAST)
        begin
            result = 24'h000001 << (code - 6'h01);
        end
        return result;
    endfunction : chanToOnehot

    // ======================================================================
    // Link shifter and interrupt pin timer

    logic csFall;
    logic frameDone;
    amx_frame_s rxFrame;
    logic timerExpire;
    logic [31:0] respWord_reg, respWord_next;

    amx_spi_shifter u_shifter (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .spiSclk(spiSclk),
        .spiCsN(spiCsN),
        .spiMosi(spiMosi),
        .txWord(respWord_reg),
        .csFall(csFall),
        .frameDone(frameDone),
        .rxFrame(rxFrame),
        .spiMiso(spiMiso),
        .spiMisoOe(spiMisoOe)
    );

    amx_delay_timer #(
        .CYCLES(INT_RELEASE_CYCLES)
    ) u_int_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .start(csFall),
        .expire(timerExpire)
    );

    // ======================================================================
    // Multiplexer control register

    logic [6:0] muxCtrl_reg, muxCtrl_next;
    logic [23:0] route_reg, route_next;
    logic muxWritten_reg, muxWritten_next;
    logic muxWrite;

    always_comb
    begin
        muxWrite = frameDone && rxFrame.write && rxFrame.addr == `AMX_ADDR_MUX_CTRL;
        muxCtrl_next = muxCtrl_reg;
        muxWritten_next = muxWritten_reg || muxWrite;
        if (muxWrite)
        begin
            // No unlock sequence is needed; a write takes effect at once. [RL5]
            muxCtrl_next = rxFrame.data[6:0];
        end
        route_next = chanToOnehot(muxCtrl_reg[`AMX_MUX_SEL_MSB:0]); // [RL2]
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            muxCtrl_reg <= `AMX_MUX_CTRL_RST; // [RL1]
            route_reg <= 24'h000000;
            muxWritten_reg <= 1'b0;
        end
        else
        begin
            muxCtrl_reg <= muxCtrl_next;
            route_reg <= route_next;
            muxWritten_reg <= muxWritten_next;
        end
    end

    assign analogChannelSel = muxCtrl_reg[`AMX_MUX_SEL_MSB:0];
    assign analogSourceCurrentSel = muxCtrl_reg[`AMX_MUX_CUR_BIT]; // [RL3]
    assign analogRoute = route_reg;

    // ======================================================================
    // Fault flags, interrupt flag and interrupt pin

    logic [EXT_FAULTS-1:0] extSticky_reg, extSticky_next;
    logic [WET_FAULTS-1:0] wetSticky_reg, wetSticky_next;
    logic porFlag_reg, porFlag_next;
    logic intFlag_reg, intFlag_next;
    logic intN_reg, intN_next;
    amx_switch_s prevSwitch_reg;
    logic faultRead;
    logic faultStatus;
    logic switchEvent;
    logic faultSetEvent;
    logic intEvent;
    logic carriesFlags;

    always_comb
    begin
        faultRead = frameDone && !rxFrame.write && rxFrame.addr == `AMX_ADDR_FAULT; // [RL19]
        // A read leaves only the conditions still present, so they reappear at once. [RL12]
        extSticky_next = faultRead ? extFaultCond : (extSticky_reg | extFaultCond); // [RL13]
        wetSticky_next = faultRead ? wetFaultCond : (wetSticky_reg | wetFaultCond); // [RL13]
        porFlag_next = porFlag_reg && !faultRead;
        faultStatus = porFlag_reg || (|extSticky_reg) || (|wetSticky_reg); // [RL9]
        switchEvent = switchClosed != prevSwitch_reg;
        // Only a flag going from clear to set counts, so a held fault stays quiet. [RL15]
        faultSetEvent = (|(extSticky_next & ~extSticky_reg))
            || (|(wetSticky_next & ~wetSticky_reg));
        intEvent = switchEvent || faultSetEvent; // [RL10]
        carriesFlags = frameDone && rxFrame.addr != `AMX_ADDR_LINK_CHECK
            && rxFrame.addr != `AMX_ADDR_WET_CFG;
        intFlag_next = intFlag_reg;
        if (intEvent)
        begin
            intFlag_next = 1'b1;
        end
        else if (carriesFlags)
        begin
            intFlag_next = 1'b0; // [RL14]
        end
        intN_next = intN_reg;
        if (intEvent)
        begin
            intN_next = 1'b0;
        end
        else if (timerExpire)
        begin
            intN_next = 1'b1; // [RL18]
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            extSticky_reg <= '0;
            wetSticky_reg <= '0;
            porFlag_reg <= 1'b1; // [RL11]
            intFlag_reg <= 1'b1; // [RL11]
            intN_reg <= 1'b0;
            prevSwitch_reg <= '0;
        end
        else
        begin
            extSticky_reg <= extSticky_next;
            wetSticky_reg <= wetSticky_next;
            porFlag_reg <= porFlag_next;
            intFlag_reg <= intFlag_next;
            intN_reg <= intN_next;
            prevSwitch_reg <= switchClosed;
        end
    end

    assign intN = intN_reg;

    // ======================================================================
    // Response word, shifted out during the following frame

    logic [21:0] statusData;
    logic [23:0] selMask;

    always_comb
    begin
        // The selected analog input reads as open. [RL4]
        selMask = chanToOnehot(muxCtrl_reg[`AMX_MUX_SEL_MSB:0]);
        statusData = switchClosed & ~selMask[21:0]; // [RL7] [RL8]
        respWord_next = respWord_reg;
        if (frameDone)
        begin
            respWord_next = {rxFrame.addr, rxFrame.write, 24'h000000};
            if (carriesFlags)
            begin
                respWord_next[`AMX_STAT_FAULT_BIT] = faultStatus; // [RL16]
                respWord_next[`AMX_STAT_INT_BIT] = intFlag_reg; // [RL16]
            end
            if (rxFrame.addr == `AMX_ADDR_SW_STATUS)
            begin
                respWord_next[21:0] = statusData; // [RL6]
            end
            else if (rxFrame.addr == `AMX_ADDR_MUX_CTRL)
            begin
                respWord_next[6:0] = muxCtrl_reg;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            respWord_reg <= 32'h00000000;
        end
        else
        begin
            respWord_reg <= respWord_next;
        end
    end

    // ======================================================================
    // Checks

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    logic statusRead;
    assign statusRead = frameDone && rxFrame.addr == `AMX_ADDR_SW_STATUS;

    AST_MUX_RESET: assert property (!muxWritten_reg |-> muxCtrl_reg == 7'h00) // [RL1]
        else $error("Mux control left reset value without a write.");

    AST_MUX_WRITE: assert property (muxWrite |=> muxCtrl_reg == $past(rxFrame.data[6:0])) // [RL5]
        else $error("Mux control write was not accepted.");

    AST_ROUTE: assert property ($changed(muxCtrl_reg) |=> ##0 $onehot0(route_reg)
        ##0 route_reg == chanToOnehot($past(muxCtrl_reg[5:0]))) // [RL2]
        else $error("Analog route does not match channel code.");

    AST_CUR_SEL: assert property (muxWrite |=> analogSourceCurrentSel == $past(rxFrame.data[6])) // [RL3]
        else $error("Source current select not taken from bit 6.");

    AST_MASK: assert property (statusRead |=> (respWord_reg[21:0] & route_reg[21:0]) == 22'h000000) // [RL4]
        else $error("Selected analog input not forced to zero.");

    AST_LAYOUT: assert property (statusRead |=> respWord_reg[31:24]
        == {`AMX_ADDR_SW_STATUS, $past(rxFrame.write)}
        && respWord_reg[21:0] == ($past(switchClosed) & ~route_reg[21:0])) // [RL8]
        else $error("Status word layout wrong.");

    AST_FAULT_OR: assert property (statusRead |=> respWord_reg[23]
        == ($past(porFlag_reg) || $past(|extSticky_reg) || $past(|wetSticky_reg))) // [RL9]
        else $error("Fault status is not the OR of fault flags.");

    AST_INT_SET: assert property (intEvent |=> intFlag_reg && !intN_reg) // [RL10]
        else $error("Interrupt event did not set flag and pin.");

    AST_INT_CLEAR: assert property (carriesFlags && !intEvent |=> !intFlag_reg) // [RL14]
        else $error("Interrupt flag not cleared after response.");

    AST_FAULT_HOLD: assert property (faultStatus && !faultRead
        |=> faultStatus) // [RL12]
        else $error("Fault status dropped without a fault read.");

    AST_RESET_AGAIN: assert property (faultRead && (|extFaultCond) |=> (|extSticky_reg)) // [RL13]
        else $error("Present fault not set again after read.");

    AST_NO_REFIRE: assert property ($past(reset_n) && !switchEvent && $stable(extFaultCond)
        && $stable(wetFaultCond) && !faultRead && $past(!faultRead) |-> !faultSetEvent) // [RL15]
        else $error("Held fault raised a new interrupt.");

    AST_PIN_RELEASE: assert property (timerExpire && !intEvent |=> intN_reg) // [RL18]
        else $error("Interrupt pin not released after delay.");

    COV_STATUS_READ: cover property (statusRead ##1 respWord_reg[22]);
    COV_MUX_WRITE: cover property (muxWrite ##1 route_reg == 24'h000000 ##1 route_reg != 24'h000000);
    COV_PIN_RELEASE: cover property (!intN_reg ##1 intN_reg);
    COV_FAULT_READ: cover property (faultRead ##1 !porFlag_reg);

endmodule : amx_switch_status
`default_nettype wire

// file: bench/amx_host_model.sv
// Host serial master model that frames 32-bit words for the switch status block.
`timescale 1ns/1ps
`default_nettype none

module amx_host_model
(
    input wire logic sys_clk,
    input wire logic spiMiso,
    output logic spiSclk,
    output logic spiCsN,
    output logic spiMosi
);
    // ========================================
    // Link pace
    // Cycles that each clock level is held; the bench raises it to play a slow host.
    int hold = 2;

    initial
    begin
        spiSclk = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end

    // ========================================
    // Frame transfer
    // A count other than 32 is only used to check that short frames are dropped.
    task automatic xfer(input logic [31:0] word, input int nbits, output logic [31:0] rx);
        rx = 32'h0;
        @(posedge sys_clk);
        spiCsN <= 1'b0;
        spiMosi <= word[31];
        repeat (hold) @(posedge sys_clk);
        for (int i = 0; i < nbits; i++)
        begin
            spiSclk <= 1'b1;
            rx = {rx[30:0], spiMiso};
            repeat (hold) @(posedge sys_clk);
            spiSclk <= 1'b0;
            spiMosi <= (i < 31) ? word[30 - i] : ~word[0];
            repeat (hold) @(posedge sys_clk);
        end
        spiCsN <= 1'b1;
        spiMosi <= ~spiMosi;
        repeat (hold + 6) @(posedge sys_clk);
    endtask : xfer
endmodule : amx_host_model
`default_nettype wire

// file: bench/amx_switch_status_tb_top.sv
// Self-checking testbench of the switch status block driven by a host model.
`timescale 1ns/1ps
`default_nettype none
`include "amx_map.svh"

module amx_switch_status_tb_top
    import amx_pkg::*;
;
    // ========================================
    // Signals
    localparam int REL = 20;
    localparam logic [6:0] SW = `AMX_ADDR_SW_STATUS;
    localparam logic [6:0] MUX = `AMX_ADDR_MUX_CTRL;
    localparam logic [6:0] FLT = `AMX_ADDR_FAULT;
    localparam logic [21:0] PAT = 22'h2A5A5;
    logic sys_clk;
    logic reset_n;
    logic spiSclk;
    logic spiCsN;
    logic spiMosi;
    logic spiMiso;
    logic spiMisoOe;
    amx_switch_s switchClosed;
    logic [7:0] extFaultCond;
    logic [21:0] wetFaultCond;
    logic [5:0] analogChannelSel;
    logic analogSourceCurrentSel;
    logic [23:0] analogRoute;
    logic intN;
    logic [31:0] resp;
    logic [7:0] lastCmd;
    logic haveCmd;
    int errTotal;
    int nTests;

    amx_switch_status #(.INT_RELEASE_CYCLES(REL)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .spiSclk(spiSclk), .spiCsN(spiCsN),
        .spiMosi(spiMosi), .switchClosed(switchClosed), .extFaultCond(extFaultCond),
        .wetFaultCond(wetFaultCond), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
        .analogChannelSel(analogChannelSel), .analogSourceCurrentSel(analogSourceCurrentSel),
        .analogRoute(analogRoute), .intN(intN));

    amx_host_model host (.sys_clk(sys_clk), .spiMiso(spiMiso), .spiSclk(spiSclk),
        .spiCsN(spiCsN), .spiMosi(spiMosi));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ========================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    // The answer to a frame comes out during the next one, so the echo lags one frame.
    task automatic xf(input logic [6:0] addr, input logic wr, input logic [23:0] data);
        host.xfer({addr, wr, data}, 32, resp);
        if (haveCmd)
            chk("echo", 32'(resp[31:24]), 32'(lastCmd));
        lastCmd = {addr, wr};
        haveCmd = 1'b1;
    endtask : xf

    task automatic stop_test();
        $display("Checks %0d errors %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // ========================================
    // Scenarios
    task automatic t_reset();
        chk("chan", 32'(analogChannelSel), 32'h0);
        chk("route", 32'(analogRoute), 32'h0);
        chk("cur", 32'(analogSourceCurrentSel), 32'h0);
        chk("intN", 32'(intN), 32'h0);
        xf(SW, 1'b0, 24'h0);
        xf(SW, 1'b0, 24'h0);
        chk("status", 32'(resp[23:0]), {8'h0, 2'b11, PAT});
        xf(SW, 1'b0, 24'h0);
        chk("flags", 32'(resp[23:22]), 32'h2);
        xf(FLT, 1'b0, 24'h0);
        xf(SW, 1'b0, 24'h0);
        xf(SW, 1'b0, 24'h0);
        chk("cleared", 32'(resp[23:22]), 32'h0);
    endtask : t_reset

    task automatic t_int_pin();
        host.hold = 6;
        switchClosed.ground[3] <= ~switchClosed.ground[3];
        repeat (3) @(posedge sys_clk);
        chk("intN set", 32'(intN), 32'h0);
        fork
            xf(SW, 1'b0, 24'h0);
            begin
                @(negedge spiCsN);
                repeat (REL + 2) @(posedge sys_clk);
                @(negedge sys_clk);
                chk("intN held", 32'(intN), 32'h0);
                @(negedge sys_clk);
                chk("intN freed", 32'(intN), 32'h1);
                chk("oe on", 32'(spiMisoOe), 32'h1);
            end
        join
        chk("oe off", 32'(spiMisoOe), 32'h0);
        xf(SW, 1'b0, 24'h0);
        chk("event", 32'(resp[22:0]), {9'h0, 1'b1, switchClosed});
        xf(SW, 1'b0, 24'h0);
        chk("flag off", 32'(resp[22]), 32'h0);
        host.hold = 2;
    endtask : t_int_pin

    task automatic t_mux();
        for (int c = 0; c < 26; c++)
        begin
            xf(MUX, 1'b1, {17'h0, c[0], c[5:0]});
            chk("chan", 32'(analogChannelSel), 32'(c[5:0]));
            chk("cur", 32'(analogSourceCurrentSel), 32'(c[0]));
            chk("route", 32'(analogRoute), (c >= 1 && c <= 24) ? 32'h1 << (c - 1) : 32'h0);
        end
    endtask : t_mux

    task automatic t_forced_zero();
        int codes[4] = '{1, 14, 15, 22};
        switchClosed <= 22'h3FFFFF;
        for (int i = 0; i < 4; i++)
        begin
            xf(MUX, 1'b1, 24'(codes[i]));
            xf(SW, 1'b0, 24'h0);
            xf(SW, 1'b0, 24'h0);
            chk("forced", 32'(resp[21:0]), 32'h3FFFFF & ~(32'h1 << (codes[i] - 1)));
        end
    endtask : t_forced_zero

    task automatic t_persist();
        for (int k = 0; k < 2; k++)
        begin
            if (k == 0)
                extFaultCond[0] <= 1'b1;
            else
                wetFaultCond[21] <= 1'b1;
            repeat (3) @(posedge sys_clk);
            chk("intN", 32'(intN), 32'h0);
            xf(SW, 1'b0, 24'h0);
            xf(SW, 1'b0, 24'h0);
            chk("raised", 32'(resp[23:22]), 32'h3);
            xf(FLT, 1'b0, 24'h0);
            xf(SW, 1'b0, 24'h0);
            xf(SW, 1'b0, 24'h0);
            chk("kept", 32'(resp[23:22]), 32'h2);
            extFaultCond <= 8'h0;
            wetFaultCond <= 22'h0;
            xf(FLT, 1'b0, 24'h0);
            xf(SW, 1'b0, 24'h0);
            xf(SW, 1'b0, 24'h0);
            chk("gone", 32'(resp[23:22]), 32'h0);
        end
    endtask : t_persist

    task automatic t_config();
        switchClosed.ground[0] <= ~switchClosed.ground[0];
        xf(`AMX_ADDR_LINK_CHECK, 1'b0, 24'h0);
        xf(`AMX_ADDR_WET_CFG, 1'b0, 24'h0);
        xf(SW, 1'b0, 24'h0);
        chk("cfg bits", 32'(resp[23:22]), 32'h0);
        xf(SW, 1'b0, 24'h0);
        chk("flag kept", 32'(resp[22]), 32'h1);
    endtask : t_config

    task automatic t_short();
        xf(MUX, 1'b1, 24'h3);
        host.xfer({MUX, 1'b1, 24'h7}, 16, resp);
        xf(SW, 1'b0, 24'h0);
        chk("chan", 32'(analogChannelSel), 32'h3);
    endtask : t_short

    // ========================================
    // Main sequence and watchdog
    initial
    begin
        reset_n = 1'b0;
        switchClosed = PAT;
        extFaultCond = 8'h0;
        wetFaultCond = 22'h0;
        errTotal = 0;
        nTests = 0;
        haveCmd = 1'b0;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_int_pin();
        t_mux();
        t_forced_zero();
        t_persist();
        t_config();
        t_short();
        stop_test();
    end

    // About 70 frames of some 150 cycles each are expected; this leaves ample margin.
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        errTotal++;
        stop_test();
    end
endmodule : amx_switch_status_tb_top
`default_nettype wire
